// ### design/berten_pkg.sv
// constants shared by the bit error rate tester files
package berten_pkg;
	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [4:0]  OFS_CTRL       = 5'h00;
	localparam logic [4:0]  OFS_PAT_CFG    = 5'h04;
	localparam logic [4:0]  OFS_SEED_LOW   = 5'h08;
	localparam logic [4:0]  OFS_SEED_HIGH  = 5'h0C;
	localparam logic [4:0]  OFS_STATUS     = 5'h10;
	localparam logic [4:0]  OFS_BIT_COUNT  = 5'h14;
	localparam logic [4:0]  OFS_ERR_COUNT  = 5'h18;
	// ------------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------------
	localparam int          CTL_ENABLE     = 0;
	localparam int          CTL_TX_LOAD    = 1;
	localparam int          CTL_RX_LOAD    = 2;
	localparam int          CTL_PMU        = 3;
	localparam int          CTL_TX_INV     = 4;
	localparam int          CTL_RX_INV     = 5;
	localparam int          CTL_NO_RESYNC  = 6;
	localparam int          CTL_ERR_SINGLE = 7;
	localparam int          CTL_ERR_PIN    = 8;
	localparam int          CTL_RATE_LO    = 9;
	localparam int          CTL_WIDTH      = 12;
	localparam logic [11:0] CTL_RESET      = 12'h000;
	// ------------------------------------------------------------------
	// pattern configuration fields
	// ------------------------------------------------------------------
	localparam int          PCR_LEN_LO     = 0;
	localparam int          PCR_REP        = 5;
	localparam int          PCR_QRSS       = 6;
	localparam int          PCR_TAP_LO     = 8;
	localparam logic [15:0] PCR_RESET      = 16'h0000;
	localparam logic [15:0] SEED_RESET     = 16'hFFFF;
	// ------------------------------------------------------------------
	// status fields and sync figures
	// ------------------------------------------------------------------
	localparam int          STS_ERR_NZ     = 0;
	localparam int          STS_OOS        = 1;
	localparam logic [5:0]  SYNC_BITS      = 6'd32;
	localparam logic [6:0]  WIN_BITS       = 7'd64;
	localparam logic [2:0]  WIN_ERR_LIMIT  = 3'd6;
	typedef enum {S_LOAD, S_VERIFY, S_SYNC} berten_sync_t;
endpackage : berten_pkg

// ### design/berten_gen_if.sv
// control and output of one pattern generator
`timescale 1ns/100ps
`default_nettype none
interface berten_gen_if;
	logic        repet;   // repetitive mode
	logic        qrss;    // qrss mode
	logic [4:0]  len_m1;  // length minus one
	logic [4:0]  tap_m1;  // tap minus one
	logic        load;    // preset with seed
	logic [31:0] seed;
	logic        step;    // advance one bit
	logic        ext_sel; // shift in ext_bit instead of feedback
	logic        ext_bit;
	logic        out;     // generator output
	modport gen (input repet, qrss, len_m1, tap_m1, load, seed, step, ext_sel, ext_bit, output out);
	modport ctl (output repet, qrss, len_m1, tap_m1, load, seed, step, ext_sel, ext_bit, input out);
endinterface : berten_gen_if
`default_nettype wire

// ### design/berten_patgen.sv
// 32-bit pattern generator shift register, instanced once each for transmit and receive
`timescale 1ns/100ps
`default_nettype none
module berten_patgen (
	// clock and reset
	input  wire logic  i_clk,
	input  wire logic  i_arst_n,
	// control
	berten_gen_if.gen  g
);
	logic [31:0] sr_q;
	logic        raw;
	logic        fb;

	// feedback selection, bit n sits at index n-1
	always_comb begin
		if (g.qrss) begin
			raw = sr_q[16] ^ sr_q[19];
		end else if (g.repet) begin
			raw = sr_q[g.len_m1];
		end else begin
			raw = sr_q[g.len_m1] ^ sr_q[g.tap_m1];
		end
		// an all-zero register would lock the sequence up forever
		fb = (!g.repet && sr_q[30:0] == 31'h0) ? 1'b1 : raw;
	end

	// output is the feedback, except qrss zero suppression
	assign g.out = (g.qrss && sr_q[13:0] == 14'h0) ? 1'b1 : fb;

	// shift from bit 1 toward bit 32
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sr_q <= 32'h0;
		end else if (g.load) begin
			sr_q <= g.seed;
		end else if (g.step) begin
			sr_q <= {sr_q[30:0], (g.ext_sel ? g.ext_bit : fb)};
		end
	end
endmodule : berten_patgen
`default_nettype wire

// ### design/berten_top.sv
// bit error rate tester: pattern generation, error insertion, sync and counting
// What this block does
// - a zero-to-one on a load bit loads the pattern into that generator while the enable bit is set.
// - pseudo-random polynomial x^n+x^y+1, n up to 32, seed up to n bits.
// - repetitive pattern of length 1 to 32 with any n-bit value.
// - 24-bit bit error counter and 32-bit received bit counter.
// - config holds tap-1 and length-1, repetitive select and qrss enable.
// - generator shifts bit 1 toward bit 32; feedback feeds bit 1 and output.
// - feedback is bit n xor bit y, or bit n when repetitive.
// - qrss feedback is bits 17 xor 20; output forced high after 14 zeros.
// - feedback forced high when bits 1 to 31 are zero, except repetitive.
// - transmit generator is preset with the seed before producing output.
// - receive checker only watches payload bits, data passes on untouched.
// - pseudo-random sync loads 32 bits then needs 32 matching bits.
// - repetitive sync tries each bit position, then needs 32 matching bits.
// - six errors in a 64-bit window start resync unless disabled.
// - out of sync flag is high whenever not in the sync state.
// - mismatch counts error and bit; match counts bit only.
// - counters hold still while out of sync.
// - error nonzero flag reads one when the error counter is above zero.
// - monitor update latches counts and clears the live counters.
// - errors inserted singly or one per 10^n bits, n 1 to 7 or off.
// - single insertion from register write or pin, chosen by config.
// - optional inversion of the outgoing pattern before overhead merge.
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module berten_top #(
	parameter int ADDR_W = 5
) (
	// clock and reset
	input  wire logic              I_CLK,
	input  wire logic              I_ARST_N,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
	input  wire logic              I_AVS_READ,
	input  wire logic              I_AVS_WRITE,
	input  wire logic [31:0]       I_AVS_WRITEDATA,
	input  wire logic [3:0]        I_AVS_BYTEENABLE,
	output logic      [31:0]       O_AVS_READDATA,
	output logic                   O_AVS_WAITREQUEST,
	// transmit payload slots from the framer
	input  wire logic              I_TX_PAY_EN,
	output logic                   O_TX_DATA,
	output logic                   O_TX_VALID,
	// receive payload from the framer
	input  wire logic              I_RX_PAY_EN,
	input  wire logic              I_RX_DATA,
	// manual error insert pin
	input  wire logic              I_MANUAL_ERROR_INSERT_IN,
	// status
	output logic                   O_OUT_OF_SYNC
);
	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// one less than ten to the power n, for the insertion rate counter
	function automatic logic [23:0] pow10_m1(input logic [2:0] n);
		case (n)
			3'h1: return 24'h000009;
			3'h2: return 24'h000063;
			3'h3: return 24'h0003E7;
			3'h4: return 24'h00270F;
			3'h5: return 24'h01869F;
			3'h6: return 24'h0F423F;
			default: return 24'h98967F;
		endcase
	endfunction : pow10_m1

	// ------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------
	logic [11:0] ctrl_q;
	logic [11:0] ctrl_prev_q;
	logic [15:0] pcr_q;
	logic [15:0] seed_low_q;
	logic [15:0] seed_high_q;
	logic [31:0] bit_cnt_q;
	logic [23:0] err_cnt_q;
	logic [31:0] bit_reg_q;
	logic [23:0] err_reg_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic        req;
	logic        commit_wr;
	logic [31:0] rd_mux;
	logic [31:0] wd_ctrl;

	assign req       = I_AVS_READ | I_AVS_WRITE;
	// a write lands at the edge where waitrequest is seen low
	assign commit_wr = I_AVS_WRITE & ~wait_q;
	assign wd_ctrl   = be_merge({20'h0, ctrl_q}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);

	// read data selection, unmapped addresses read zero
	always_comb begin
		case (I_AVS_ADDRESS)
			berten_pkg::OFS_CTRL:      rd_mux = {20'h0, ctrl_q};
			berten_pkg::OFS_PAT_CFG:   rd_mux = {16'h0, pcr_q};
			berten_pkg::OFS_SEED_LOW:  rd_mux = {16'h0, seed_low_q};
			berten_pkg::OFS_SEED_HIGH: rd_mux = {16'h0, seed_high_q};
			berten_pkg::OFS_STATUS:    rd_mux = {30'h0, O_OUT_OF_SYNC, err_cnt_q != 24'h0};
			berten_pkg::OFS_BIT_COUNT: rd_mux = bit_reg_q;
			berten_pkg::OFS_ERR_COUNT: rd_mux = {8'h0, err_reg_q};
			default:                   rd_mux = 32'h0;
		endcase
	end

	// two-cycle handshake: waitrequest drops for one cycle per access
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			wait_q  <= ~(req & wait_q);
			rdata_q <= (I_AVS_READ & wait_q) ? rd_mux : rdata_q;
		end
	end
	assign O_AVS_WAITREQUEST = wait_q;
	assign O_AVS_READDATA    = rdata_q;

	// software writable registers
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ctrl_q      <= berten_pkg::CTL_RESET;
			ctrl_prev_q <= berten_pkg::CTL_RESET;
			pcr_q       <= berten_pkg::PCR_RESET;
			seed_low_q  <= berten_pkg::SEED_RESET;
			seed_high_q <= berten_pkg::SEED_RESET;
		end else begin
			ctrl_prev_q <= ctrl_q;
			if (commit_wr && I_AVS_ADDRESS == berten_pkg::OFS_CTRL) begin
				ctrl_q <= wd_ctrl[11:0];
			end
			if (commit_wr && I_AVS_ADDRESS == berten_pkg::OFS_PAT_CFG) begin
				pcr_q <= 16'(be_merge({16'h0, pcr_q}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
			end
			if (commit_wr && I_AVS_ADDRESS == berten_pkg::OFS_SEED_LOW) begin
				seed_low_q <= 16'(be_merge({16'h0, seed_low_q}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
			end
			if (commit_wr && I_AVS_ADDRESS == berten_pkg::OFS_SEED_HIGH) begin
				seed_high_q <= 16'(be_merge({16'h0, seed_high_q}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
			end
		end
	end

	// ------------------------------------------------------------------
	// decoded configuration and events
	// ------------------------------------------------------------------
	logic       enable;
	logic       tx_load;
	logic       rx_load;
	logic       pmu_evt;
	logic [2:0] rate_n;
	logic       sw_single;

	assign enable    = ctrl_q[berten_pkg::CTL_ENABLE];
	// loads act on the rising edge of the stored bit, only while enabled
	assign tx_load   = enable & ctrl_q[berten_pkg::CTL_TX_LOAD] & ~ctrl_prev_q[berten_pkg::CTL_TX_LOAD];
	assign rx_load   = enable & ctrl_q[berten_pkg::CTL_RX_LOAD] & ~ctrl_prev_q[berten_pkg::CTL_RX_LOAD];
	assign pmu_evt   = ctrl_q[berten_pkg::CTL_PMU] & ~ctrl_prev_q[berten_pkg::CTL_PMU];
	assign rate_n    = ctrl_q[berten_pkg::CTL_RATE_LO +: 3];
	// the single insert bit is a strobe: writing one requests one error
	assign sw_single = commit_wr & (I_AVS_ADDRESS == berten_pkg::OFS_CTRL) & wd_ctrl[berten_pkg::CTL_ERR_SINGLE];

	// ------------------------------------------------------------------
	// pattern generators
	// ------------------------------------------------------------------
	berten_gen_if tx_g ();
	berten_gen_if rx_g ();
	logic rx_bit;
	logic rx_miss;
	logic rx_shift_in;
	berten_pkg::berten_sync_t state_q;

	// both generators share the configuration; n and y are stored minus one
	always_comb begin
		tx_g.repet   = pcr_q[berten_pkg::PCR_REP];
		tx_g.qrss    = pcr_q[berten_pkg::PCR_QRSS];
		tx_g.len_m1  = pcr_q[berten_pkg::PCR_LEN_LO +: 5];
		tx_g.tap_m1  = pcr_q[berten_pkg::PCR_TAP_LO +: 5];
		tx_g.seed    = {seed_high_q, seed_low_q};
		tx_g.load    = tx_load;
		tx_g.step    = I_TX_PAY_EN & ~tx_load;
		tx_g.ext_sel = 1'b0;
		tx_g.ext_bit = 1'b0;
		rx_g.repet   = pcr_q[berten_pkg::PCR_REP];
		rx_g.qrss    = pcr_q[berten_pkg::PCR_QRSS];
		rx_g.len_m1  = pcr_q[berten_pkg::PCR_LEN_LO +: 5];
		rx_g.tap_m1  = pcr_q[berten_pkg::PCR_TAP_LO +: 5];
		rx_g.seed    = {seed_high_q, seed_low_q};
		rx_g.load    = rx_load;
		rx_g.step    = I_RX_PAY_EN & ~rx_load;
		rx_g.ext_sel = rx_shift_in;
		rx_g.ext_bit = rx_bit;
	end

	berten_patgen u_tx_gen (
		.i_clk    (I_CLK),
		.i_arst_n (I_ARST_N),
		.g        (tx_g.gen)
	);

	berten_patgen u_rx_gen (
		.i_clk    (I_CLK),
		.i_arst_n (I_ARST_N),
		.g        (rx_g.gen)
	);

	// ------------------------------------------------------------------
	// transmit error insertion
	// ------------------------------------------------------------------
	logic [1:0]  pin_sync_q;
	logic        pin_prev_q;
	logic        single_q;
	logic [23:0] rate_cnt_q;
	logic        pin_edge;
	logic        rate_hit;
	logic        ins_err;

	assign pin_edge = pin_sync_q[1] & ~pin_prev_q;
	assign rate_hit = (rate_n != 3'h0) && (rate_cnt_q == pow10_m1(rate_n));
	assign ins_err  = I_TX_PAY_EN & (single_q | rate_hit);

	// the pin is asynchronous, so two flops come before the edge detector
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pin_sync_q <= 2'b00;
			pin_prev_q <= 1'b0;
		end else begin
			pin_sync_q <= {pin_sync_q[0], I_MANUAL_ERROR_INSERT_IN};
			pin_prev_q <= pin_sync_q[1];
		end
	end

	// pending single error; a new request in the consuming cycle survives
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			single_q <= 1'b0;
		end else if (ctrl_q[berten_pkg::CTL_ERR_PIN] ? pin_edge : sw_single) begin
			single_q <= 1'b1;
		end else if (I_TX_PAY_EN) begin
			single_q <= 1'b0;
		end
	end

	// payload bits since the last rate error
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rate_cnt_q <= 24'h0;
		end else if (rate_n == 3'h0) begin
			rate_cnt_q <= 24'h0;
		end else if (I_TX_PAY_EN) begin
			rate_cnt_q <= rate_hit ? 24'h0 : rate_cnt_q + 24'h1;
		end
	end

	// outgoing bit, inverted when the tx invert bit is set, before the framer merges its overhead
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_TX_DATA  <= 1'b0;
			O_TX_VALID <= 1'b0;
		end else begin
			O_TX_VALID <= I_TX_PAY_EN;
			if (I_TX_PAY_EN) begin
				O_TX_DATA <= tx_g.out ^ ins_err ^ ctrl_q[berten_pkg::CTL_TX_INV];
			end
		end
	end

	// ------------------------------------------------------------------
	// receive synchronisation
	// ------------------------------------------------------------------
	berten_pkg::berten_sync_t state_d;
	logic [5:0] sync_cnt_q;
	logic [6:0] win_cnt_q;
	logic [2:0] win_err_q;
	logic       resync;

	assign rx_bit  = I_RX_DATA ^ ctrl_q[berten_pkg::CTL_RX_INV];
	assign rx_miss = rx_bit ^ rx_g.out;
	// loading pulls the incoming bits in; repetitive mode slides one position per miss
	assign rx_shift_in = (state_q == berten_pkg::S_LOAD)
		| (state_q == berten_pkg::S_VERIFY && rx_miss && rx_g.repet);
	assign resync  = ~ctrl_q[berten_pkg::CTL_NO_RESYNC] & rx_miss & (win_err_q == berten_pkg::WIN_ERR_LIMIT - 3'd1);

	always_comb begin
		state_d = state_q;
		case (state_q)
			berten_pkg::S_LOAD: begin
				if (I_RX_PAY_EN && sync_cnt_q == berten_pkg::SYNC_BITS - 6'd1) begin
					state_d = berten_pkg::S_VERIFY;
				end
			end
			berten_pkg::S_VERIFY: begin
				if (I_RX_PAY_EN && rx_miss && !rx_g.repet) begin
					state_d = berten_pkg::S_LOAD;
				end else if (I_RX_PAY_EN && !rx_miss && sync_cnt_q == berten_pkg::SYNC_BITS - 6'd1) begin
					state_d = berten_pkg::S_SYNC;
				end
			end
			berten_pkg::S_SYNC: begin
				if (I_RX_PAY_EN && resync) begin
					state_d = berten_pkg::S_LOAD;
				end
			end
			default: state_d = berten_pkg::S_LOAD;
		endcase
		if (rx_load) begin
			state_d = berten_pkg::S_LOAD;
		end
	end

	// sync state, bit counter for load and verify phases
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_q       <= berten_pkg::S_LOAD;
			sync_cnt_q    <= 6'h0;
			O_OUT_OF_SYNC <= 1'b1;
		end else begin
			state_q       <= state_d;
			O_OUT_OF_SYNC <= (state_d != berten_pkg::S_SYNC);
			if (state_d != state_q || rx_load || (state_q == berten_pkg::S_VERIFY && I_RX_PAY_EN && rx_miss)) begin
				sync_cnt_q <= 6'h0;
			end else if (I_RX_PAY_EN) begin
				sync_cnt_q <= sync_cnt_q + 6'h1;
			end
		end
	end

	// errors within each 64-bit window while in sync
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			win_cnt_q <= 7'h0;
			win_err_q <= 3'h0;
		end else if (state_q != berten_pkg::S_SYNC || state_d != berten_pkg::S_SYNC) begin
			win_cnt_q <= 7'h0;
			win_err_q <= 3'h0;
		end else if (I_RX_PAY_EN) begin
			if (win_cnt_q == berten_pkg::WIN_BITS - 7'd1) begin
				win_cnt_q <= 7'h0;
				win_err_q <= 3'h0;
			end else begin
				win_cnt_q <= win_cnt_q + 7'h1;
				// saturates so a disabled resync cannot wrap the count
				if (rx_miss && win_err_q != berten_pkg::WIN_ERR_LIMIT) begin
					win_err_q <= win_err_q + 3'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// bit and error counters
	// ------------------------------------------------------------------
	logic count_now;
	assign count_now = I_RX_PAY_EN & ~O_OUT_OF_SYNC;

	// live counters; a bit in the update cycle starts the new period
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			bit_cnt_q <= 32'h0;
			err_cnt_q <= 24'h0;
		end else if (pmu_evt) begin
			bit_cnt_q <= {31'h0, count_now};
			err_cnt_q <= {23'h0, count_now & rx_miss};
		end else if (count_now) begin
			bit_cnt_q <= bit_cnt_q + 32'h1;
			err_cnt_q <= err_cnt_q + {23'h0, rx_miss};
		end
	end

	// software-visible copies taken at each monitor update
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			bit_reg_q <= 32'h0;
			err_reg_q <= 24'h0;
		end else if (pmu_evt) begin
			bit_reg_q <= bit_cnt_q;
			err_reg_q <= err_cnt_q;
		end
	end
endmodule : berten_top
`default_nettype wire

// ### sim/berten_chk.sv
// port assertions for the bit error rate tester
`timescale 1ns/100ps
`default_nettype none
module berten_chk (
	// clock and reset
	input wire logic        I_CLK,
	input wire logic        I_ARST_N,
	// register bus
	input wire logic        I_AVS_READ,
	input wire logic        I_AVS_WRITE,
	input wire logic [31:0] O_AVS_READDATA,
	input wire logic        O_AVS_WAITREQUEST,
	// payload and status
	input wire logic        I_TX_PAY_EN,
	input wire logic        O_TX_DATA,
	input wire logic        O_TX_VALID,
	input wire logic        I_RX_PAY_EN,
	input wire logic        O_OUT_OF_SYNC
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	logic [6:0] oos_bits_q;
	// ------------------------------
	// bits taken while out of sync
	// ------------------------------
	// saturates so a long search never wraps back under the minimum
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N)
			oos_bits_q <= 7'h00;
		else if (!O_OUT_OF_SYNC)
			oos_bits_q <= 7'h00;
		else if (I_RX_PAY_EN && oos_bits_q != 7'h7F)
			oos_bits_q <= oos_bits_q + 7'h01;
	end
	// a request is answered after exactly one wait cycle
	sequence s_req;
		(I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
	endsequence
	sequence s_answer;
		!O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
	endsequence
	AST_ONE_WAIT: assert property (s_req |=> s_answer)
		else $error("bus answer not after one wait cycle");
	AST_NO_ANSWER: assert property (!(I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("bus answered without a request");
	AST_RDATA_HOLD: assert property ($changed(O_AVS_READDATA) |-> !O_AVS_WAITREQUEST && $past(I_AVS_READ))
		else $error("read data moved outside a read answer");
	AST_TX_VALID: assert property (O_TX_VALID == $past(I_TX_PAY_EN))
		else $error("transmit valid not one cycle after the slot");
	AST_TX_HOLD: assert property ($changed(O_TX_DATA) |-> O_TX_VALID)
		else $error("transmit bit moved without valid");
	AST_RESET_STATE: assert property ($rose(I_ARST_N) |-> O_OUT_OF_SYNC && !O_TX_VALID && O_AVS_WAITREQUEST)
		else $error("outputs not idle after reset");
	AST_SYNC_MIN: assert property ($fell(O_OUT_OF_SYNC) |-> oos_bits_q >= 7'h40)
		else $error("sync reached with fewer than 64 bits");
	AST_SYNC_ON_BIT: assert property ($fell(O_OUT_OF_SYNC) |-> $past(I_RX_PAY_EN))
		else $error("sync reached without a received bit");
endmodule : berten_chk
bind berten_top berten_chk u_berten_chk (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_AVS_READ(I_AVS_READ),
	.I_AVS_WRITE(I_AVS_WRITE), .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
	.I_TX_PAY_EN(I_TX_PAY_EN), .O_TX_DATA(O_TX_DATA), .O_TX_VALID(O_TX_VALID), .I_RX_PAY_EN(I_RX_PAY_EN),
	.O_OUT_OF_SYNC(O_OUT_OF_SYNC));
`default_nettype wire

// ### sim/berten_framer.sv
// framer payload model: asks for transmit bits and loops them back as receive payload
`timescale 1ns/100ps
`default_nettype none
module berten_framer (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	// bench control
	input  wire logic i_run,
	input  wire logic i_slow,
	// tester payload
	input  wire logic i_tx_data,
	input  wire logic i_tx_valid,
	output logic      o_tx_pay_en,
	output logic      o_rx_pay_en,
	output logic      o_rx_data
);
	logic ph_q;
	// -----------------------
	// slots and loopback
	// -----------------------
	// slow mode offers a slot every other cycle; idle line toggles so stale data never looks valid
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ph_q        <= 1'b0;
			o_tx_pay_en <= 1'b0;
			o_rx_pay_en <= 1'b0;
			o_rx_data   <= 1'b0;
		end else begin
			ph_q        <= !ph_q;
			o_tx_pay_en <= i_run && (!i_slow || ph_q);
			o_rx_pay_en <= i_tx_valid;
			o_rx_data   <= i_tx_valid ? i_tx_data : !o_rx_data;
		end
	end
endmodule : berten_framer
`default_nettype wire

// ### sim/berten_top_tb.sv
// self-checking bench for the bit error rate tester
`timescale 1ns/100ps
`default_nettype none
module berten_top_tb;
	// ------------------------------
	// signals and reference state
	// ------------------------------
	localparam logic [4:0] a_ct = berten_pkg::OFS_CTRL;
	localparam logic [4:0] a_pc = berten_pkg::OFS_PAT_CFG;
	localparam logic [4:0] a_st = berten_pkg::OFS_STATUS;
	localparam logic [4:0] a_bc = berten_pkg::OFS_BIT_COUNT;
	localparam logic [4:0] a_ec = berten_pkg::OFS_ERR_COUNT;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic        re = 1'b0;
	logic        we = 1'b0;
	logic [31:0] wd = 32'h0;
	logic        run = 1'b0;
	logic        slow = 1'b0;
	logic        mei = 1'b0;
	logic        rinv = 1'b0;
	logic        rrep, rq, wrq, tx_en, tx_d, tx_v, rx_en, rx_d, out_of_sync;
	logic [31:0] rdv, rdata, ctl, rr;
	int          rn, ry;
	int          mismatches = 0;
	int          checked = 0;
	int          cyc = 0;
	// 250 MHz clock
	always #2 clk = ~clk;
	berten_top u_berten_top (.I_CLK(clk), .I_ARST_N(rst_n), .I_AVS_ADDRESS(adr), .I_AVS_READ(re),
		.I_AVS_WRITE(we), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdv),
		.O_AVS_WAITREQUEST(wrq), .I_TX_PAY_EN(tx_en), .O_TX_DATA(tx_d), .O_TX_VALID(tx_v),
		.I_RX_PAY_EN(rx_en), .I_RX_DATA(rx_d), .I_MANUAL_ERROR_INSERT_IN(mei), .O_OUT_OF_SYNC(out_of_sync));
	berten_framer u_berten_framer (.i_clk(clk), .i_arst_n(rst_n), .i_run(run), .i_slow(slow),
		.i_tx_data(tx_d), .i_tx_valid(tx_v), .o_tx_pay_en(tx_en), .o_rx_pay_en(rx_en), .o_rx_data(rx_d));
	// a hang ends the run as a failure
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 32'h0000_4E20) begin
			mismatches++;
			final_report();
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	// request held until waitrequest is seen low at an edge
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		we <= w;
		re <= !w;
		@(posedge clk);
		while (wrq !== 1'b0) @(posedge clk);
		rdata = rdv;
		we <= 1'b0;
		re <= 1'b0;
	endtask : bus
	task wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rdchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rdata, e);
	endtask : rdchk
	// one reference bit, then shift
	task nxt(output logic b);
		logic fb;
		fb = rrep ? rr[rn-1] : (rq ? rr[16] ^ rr[19] : rr[rn-1] ^ rr[ry-1]);
		if (!rrep && rr[30:0] == 31'h0) fb = 1'b1;
		b = ((rq && rr[13:0] == 14'h0) ? 1'b1 : fb) ^ rinv;
		rr = {rr[30:0], fb};
	endtask : nxt
	task cfg(input logic [15:0] pc, input logic [31:0] sd);
		wr(a_pc, {16'h0, pc});
		wr(berten_pkg::OFS_SEED_LOW, {16'h0, sd[15:0]});
		wr(berten_pkg::OFS_SEED_HIGH, {16'h0, sd[31:16]});
		rdchk(a_pc, {16'h0, pc});
		rr = sd;
		rn = int'(pc[4:0]) + 1;
		ry = int'(pc[12:8]) + 1;
		rrep = pc[5];
		rq = pc[6];
	endtask : cfg
	// loads are rising edges, so clear first
	task load(input logic [31:0] bits);
		wr(a_ct, ctl);
		wr(a_ct, ctl | bits);
		repeat (3) @(posedge clk);
	endtask : load
	task pmu();
		wr(a_ct, ctl);
		wr(a_ct, ctl | 32'h8);
		repeat (2) @(posedge clk);
	endtask : pmu
	task txchk(input int n);
		int k;
		logic b;
		k = 0;
		run <= 1'b1;
		while (k < n) begin
			@(negedge clk);
			if (tx_v === 1'b1) begin
				nxt(b);
				check(tx_d, b);
				k++;
			end
		end
		@(posedge clk);
		run <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : txchk
	task waitsync();
		run <= 1'b1;
		while (out_of_sync !== 1'b0) @(negedge clk);
		check(out_of_sync, 1'b0);
		@(posedge clk);
		run <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : waitsync
	// exactly n payload slots, then drain the loop
	task send(input int n);
		run <= 1'b1;
		repeat (n) @(posedge clk);
		run <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : send
	task pin();
		mei <= 1'b1;
		repeat (3) @(posedge clk);
		mei <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pin
	// ------------------------------
	// scenarios
	// ------------------------------
	task t_reset();
		rdchk(a_ct, 32'h0);
		rdchk(berten_pkg::OFS_SEED_LOW, 32'hFFFF);
		wr(a_st, 32'hFFFF_FFFF);
		wr(a_bc, 32'hFFFF_FFFF);
		wr(5'h1C, 32'hFFFF_FFFF);
		rdchk(a_st, 32'h2);
		rdchk(a_bc, 32'h0);
		rdchk(a_ec, 32'h0);
		rdchk(5'h1C, 32'h0);
	endtask : t_reset
	task t_gate();
		cfg(16'h0020, 32'hFFFF_FFFF);
		rr = 32'h0;
		ctl = 32'h0;
		load(32'h2);
		txchk(8);
		ctl = 32'h1;
		rr = 32'hFFFF_FFFF;
		load(32'h2);
		txchk(8);
	endtask : t_gate
	task t_patterns();
		logic [15:0] pc [5];
		logic [31:0] sd [5];
		pc = '{16'h0408, 16'h0253, 16'h0D0E, 16'h0408, 16'h003F};
		sd = '{32'h0000_01A5, 32'hFFFF_FFFF, 32'h0000_5A5A, 32'h0, 32'h8000_0001};
		for (int i = 0; i < 5; i++) begin
			cfg(pc[i], sd[i]);
			load(32'h2);
			txchk(80);
		end
	endtask : t_patterns
	// inverted one-in-eight syncs with the receive side undoing the inversion
	task t_rep_sync();
		ctl = 32'h31;
		cfg(16'h0027, 32'hFFFF_FF01);
		rinv = 1'b1;
		load(32'h6);
		txchk(40);
		slow <= 1'b1;
		waitsync();
		pmu();
		rdchk(a_st, 32'h0);
		slow <= 1'b0;
		rinv = 1'b0;
	endtask : t_rep_sync
	// resync off so one error in ten cannot drop sync
	task t_count();
		ctl = 32'h41;
		cfg(16'h0408, 32'hFFFF_FFFF);
		load(32'h6);
		waitsync();
		pmu();
		ctl = 32'h241;
		wr(a_ct, ctl);
		send(100);
		rdchk(a_st, 32'h1);
		pmu();
		rdchk(a_bc, 32'h64);
		rdchk(a_ec, 32'hA);
		rdchk(a_st, 32'h0);
	endtask : t_count
	task t_resync();
		ctl = 32'h201;
		wr(a_ct, ctl);
		send(100);
		check(out_of_sync, 1'b1);
		ctl = 32'h1;
		pmu();
		send(30);
		pmu();
		rdchk(a_bc, 32'h0);
		rdchk(a_ec, 32'h0);
	endtask : t_resync
	task t_single();
		ctl = 32'h41;
		wr(a_ct, ctl);
		waitsync();
		pmu();
		pin();
		wr(a_ct, ctl | 32'h80);
		send(20);
		ctl = 32'h141;
		wr(a_ct, ctl);
		pin();
		send(20);
		pmu();
		rdchk(a_bc, 32'h28);
		rdchk(a_ec, 32'h2);
	endtask : t_single
	task final_report();
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	// reset for ten cycles, then the scenarios in turn
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_gate();
		t_patterns();
		t_rep_sync();
		t_count();
		t_resync();
		t_single();
		final_report();
	end
endmodule : berten_top_tb
`default_nettype wire
